// [ctrl_port_pkg.sv]
// Constants and carrier types for the video decoder control port
`default_nettype none
package ctrl_port_pkg;
  localparam int         REG_COUNT     = 64;
  localparam logic [5:0] PTR_LAST      = 6'h3F;
  localparam logic [3:0] DEV_ADDR_HIGH = 4'h4;
  localparam logic [7:0] READ_IDLE     = 8'hFF;

  typedef struct packed {
    logic       chip_select_n;
    logic       read_not_write;
    logic       pointer_data_select;
    logic [7:0] host_data_bus;
  } par_in_t;

  typedef struct packed {
    logic [7:0] host_data_bus;
    logic       host_data_oe;
  } par_out_t;
endpackage : ctrl_port_pkg
`default_nettype wire

// [host_model.sv]
// Host processor model for the parallel and two-wire ports
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic                    sys_clk,
  input  wire ctrl_port_pkg::par_out_t par_out,
  input  wire logic                    sda_oe,
  output var  ctrl_port_pkg::par_in_t  par_in,
  output logic                         scl_in,
  output logic                         sda_in
);
  import ctrl_port_pkg::*;
  logic pull;
  // Open-drain wire with pull-up
  assign sda_in = !(pull || sda_oe);
  initial begin
    par_in = '{1'b1, 1'b1, 1'b0, 8'h00};
    scl_in = 1'b1;
    pull   = 1'b0;
  end
  task automatic pacc(input logic sel, input logic rnw, input logic [7:0] wd,
                      output logic [8:0] rd);
    @(negedge sys_clk);
    // Reads leave the bus to the device, so drive junk
    par_in = '{1'b0, rnw, sel, rnw ? ~wd : wd};
    repeat (7) @(negedge sys_clk);
    rd = {par_out.host_data_oe, par_out.host_data_bus};
    par_in.chip_select_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask : pacc
  task automatic sbit(input logic b, output logic r);
    // Data moves only well after SCL falls
    repeat (2) @(negedge sys_clk);
    pull = !b;
    repeat (4) @(negedge sys_clk);
    scl_in = 1'b1;
    repeat (3) @(negedge sys_clk);
    r = sda_in;
    repeat (3) @(negedge sys_clk);
    scl_in = 1'b0;
  endtask : sbit
  task automatic sbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(d[i], r);
    sbit(1'b1, r);
    ack = !r;
  endtask : sbyte
  // Read byte: SDA left released while the device shifts out, then ACK or NACK
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      sbit(1'b1, r);
      d[i] = r;
    end
    sbit(nack, r);
  endtask : rbyte
  task automatic start();
    pull = 1'b1;
    repeat (6) @(negedge sys_clk);
    scl_in = 1'b0;
  endtask : start
  task automatic stop();
    repeat (2) @(negedge sys_clk);
    pull = 1'b1;
    repeat (4) @(negedge sys_clk);
    scl_in = 1'b1;
    repeat (6) @(negedge sys_clk);
    pull = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask : stop
endmodule : host_model
`default_nettype wire

// [video_decoder_control_port.sv]
// Parallel and two-wire register port with pointer, register file and power-down
`timescale 1ns/100ps
`default_nettype none
module video_decoder_control_port (
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic                     interface_select_n,
  input  wire ctrl_port_pkg::par_in_t   par_in,
  output var  ctrl_port_pkg::par_out_t  par_out,
  input  wire logic [2:0]               serial_addr_select,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_oe,
  output logic                          sda_out,
  output logic                          power_down,
  output logic [8*64-1:0]               reg_image
);
  import ctrl_port_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_DEVADR, S_ACK, S_SUB, S_WDATA, S_RDATA, S_RACK} ser_st_t;

  // Chip select, SCL, SDA and interface select pass three stages; a change counts when stages two and three agree
  logic [3:0] s1_r, s2_r, s3_r, f_r;
  logic [3:0] raw;
  assign raw = {par_in.chip_select_n, scl_in, sda_in, interface_select_n};
  always_ff @(posedge sys_clk) begin
    s1_r <= raw;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  logic [3:0] f_nxt;
  always_comb begin
    for (int i = 0; i < 4; i++) f_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : f_r[i];
  end
  always_ff @(posedge sys_clk) begin
    if (srst) f_r <= 4'hF;
    else f_r <= f_nxt;
  end
  logic cs_n, scl, sda, ser_mode, cs_prev_r, scl_prev_r, sda_prev_r;
  assign cs_n     = f_r[3];
  assign scl      = f_r[2];
  assign sda      = f_r[1];
  assign ser_mode = ~f_r[0];
  always_ff @(posedge sys_clk) begin
    cs_prev_r  <= cs_n;
    scl_prev_r <= scl;
    sda_prev_r <= sda;
  end
  logic cs_fall, cs_rise, scl_rise, scl_fall, start_c, stop_c;
  assign cs_fall  = cs_prev_r & ~cs_n & ~ser_mode;
  assign cs_rise  = ~cs_prev_r & cs_n & ~ser_mode;
  assign scl_rise = ~scl_prev_r & scl & ser_mode;
  assign scl_fall = scl_prev_r & ~scl & ser_mode;
  assign start_c  = ser_mode & scl & scl_prev_r & sda_prev_r & ~sda;
  assign stop_c   = ser_mode & scl & scl_prev_r & ~sda_prev_r & sda;

  // Register file has no reset so contents survive power-down
  logic [7:0] regs [REG_COUNT];
  logic [5:0] ptr_r, ptr_nxt;
  logic       wr_en;
  logic [7:0] wr_data;
  always_ff @(posedge sys_clk) begin
    if (wr_en) regs[ptr_r] <= wr_data;
  end
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_img
      always_ff @(posedge sys_clk) reg_image[8*g +: 8] <= regs[g];
    end
  endgenerate

  // Serial engine state
  ser_st_t    st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic       rd_r, rd_nxt, ack_r, ack_nxt, drv_r, drv_nxt;
  ser_st_t    after_ack_r, after_ack_nxt;
  par_out_t   po_nxt;
  logic       par_latch_r, par_latch_nxt;

  function automatic logic [5:0] bump(input logic [5:0] p);
    return (p == PTR_LAST) ? p : p + 6'h01;
  endfunction

  always_comb begin
    st_nxt = st_r; sh_nxt = sh_r; bit_nxt = bit_r; rd_nxt = rd_r;
    ack_nxt = ack_r; drv_nxt = drv_r; after_ack_nxt = after_ack_r;
    ptr_nxt = ptr_r; wr_en = 1'b0; wr_data = sh_r;
    po_nxt = par_out; par_latch_nxt = par_latch_r;
    // Parallel port: sample data near the strobe, act on its release
    if (cs_fall) begin
      par_latch_nxt = 1'b1;
      if (par_in.read_not_write) begin
        po_nxt.host_data_oe = 1'b1;
        po_nxt.host_data_bus = par_in.pointer_data_select ? regs[ptr_r] : {2'b00, ptr_r};
      end
    end
    if (cs_rise && par_latch_r) begin
      par_latch_nxt = 1'b0;
      po_nxt.host_data_oe = 1'b0;
      if (!par_in.pointer_data_select) begin
        if (!par_in.read_not_write) ptr_nxt = par_in.host_data_bus[5:0];
      end else begin
        if (!par_in.read_not_write) begin
          wr_en = 1'b1;
          wr_data = par_in.host_data_bus;
        end
        ptr_nxt = bump(ptr_r);
      end
    end
    // Serial engine; START restarts from any state
    if (start_c) begin
      st_nxt = S_DEVADR; bit_nxt = 4'h0; drv_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = S_IDLE; drv_nxt = 1'b0;
    end else if (!ser_mode) begin
      // Leaving serial mode drops any transfer so SDA is never left held low
      st_nxt = S_IDLE;
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        S_IDLE: drv_nxt = 1'b0;
        S_DEVADR, S_SUB, S_WDATA: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == 4'h8) begin
            bit_nxt = 4'h0;
            if (st_r == S_DEVADR) begin
              if (sh_r[7:1] == {DEV_ADDR_HIGH, serial_addr_select}) begin
                rd_nxt = sh_r[0];
                drv_nxt = 1'b1; ack_nxt = 1'b0;
                st_nxt = S_ACK;
                after_ack_nxt = sh_r[0] ? S_RDATA : S_SUB;
              end else st_nxt = S_IDLE;
            end else begin
              if (st_r == S_SUB) ptr_nxt = sh_r[5:0];
              else begin
                wr_en = 1'b1;
                wr_data = sh_r;
                ptr_nxt = bump(ptr_r);
              end
              drv_nxt = 1'b1; ack_nxt = 1'b0;
              st_nxt = S_ACK;
              after_ack_nxt = S_WDATA;
            end
          end
        end
        S_ACK: if (scl_fall) begin
          if (after_ack_r == S_RDATA) begin
            sh_nxt = regs[ptr_r];
            ptr_nxt = bump(ptr_r);
            drv_nxt = ~regs[ptr_r][7];
            ack_nxt = 1'b0;
            bit_nxt = 4'h1;
          end else drv_nxt = 1'b0;
          st_nxt = after_ack_r;
        end
        S_RDATA: if (scl_fall) begin
          if (bit_r == 4'h8) begin
            drv_nxt = 1'b0; st_nxt = S_RACK; bit_nxt = 4'h0;
          end else begin
            drv_nxt = ~sh_r[3'h7 - bit_r[2:0]];
            bit_nxt = bit_r + 4'h1;
          end
        end
        S_RACK: if (scl_rise) begin
          // Master NACK ends the read; ACK fetches the next byte
          st_nxt = sda ? S_IDLE : S_ACK;
          after_ack_nxt = S_RDATA;
        end
        default: st_nxt = S_IDLE;
      endcase
    end
  end

  // Reset clears state machines but never the register array
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= S_IDLE; sh_r <= 8'h00; bit_r <= 4'h0; rd_r <= 1'b0;
      ack_r <= 1'b0; drv_r <= 1'b0; after_ack_r <= S_IDLE;
      ptr_r <= 6'h00; par_latch_r <= 1'b0;
      par_out <= '{host_data_bus: READ_IDLE, host_data_oe: 1'b0};
      power_down <= 1'b1;
    end else begin
      st_r <= st_nxt; sh_r <= sh_nxt; bit_r <= bit_nxt; rd_r <= rd_nxt;
      ack_r <= ack_nxt; drv_r <= drv_nxt; after_ack_r <= after_ack_nxt;
      ptr_r <= ptr_nxt; par_latch_r <= par_latch_nxt;
      par_out <= po_nxt;
      power_down <= 1'b0;
    end
  end
  // Open drain: only ever pulls low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sda_oe <= 1'b0; sda_out <= 1'b0;
    end else begin
      sda_oe <= drv_nxt; sda_out <= 1'b0;
    end
  end

  ptr_sticks_a: assert property (@(posedge sys_clk) disable iff (srst)
    (ptr_r == PTR_LAST && !(cs_rise && par_latch_r && !par_in.pointer_data_select)
     && st_r != S_SUB) |=> ptr_r == PTR_LAST)
    else $error("pointer left 3Fh");
  ptr_bump_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cs_rise && par_latch_r && par_in.pointer_data_select && ptr_r != PTR_LAST && st_r == S_IDLE)
    |=> ptr_r == $past(ptr_r) + 6'h01)
    else $error("pointer not advanced");
  par_oe_a: assert property (@(posedge sys_clk) disable iff (srst)
    par_out.host_data_oe |-> par_in.read_not_write || $past(cs_rise))
    else $error("bus driven on write");
  reset_pd_a: assert property (@(posedge sys_clk)
    srst |=> power_down && st_r == S_IDLE)
    else $error("reset did not power down");
  ser_off_a: assert property (@(posedge sys_clk) disable iff (srst)
    !ser_mode |=> st_r == S_IDLE && !sda_oe)
    else $error("serial busy in parallel mode");
  sda_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    sda_oe |-> (st_r == S_ACK || st_r == S_RDATA) && !sda_out)
    else $error("sda driven outside ack or read data");
  ptr_load_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cs_rise && par_latch_r && !par_in.pointer_data_select && !par_in.read_not_write
     && st_r == S_IDLE) |=> ptr_r == $past(par_in.host_data_bus[5:0]))
    else $error("pointer not loaded");
  ser_ptr_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r == S_SUB && scl_fall && bit_r == 4'h8 && !start_c && !stop_c) |=> st_r == S_ACK)
    else $error("no ack after sub-address");
endmodule : video_decoder_control_port
`default_nettype wire

// [video_decoder_control_port_bench.sv]
// Self-checking bench for the control port
`timescale 1ns/100ps
`default_nettype none
module video_decoder_control_port_bench;
  import ctrl_port_pkg::*;
  logic sys_clk, srst, interface_select_n, scl_in, sda_in, sda_oe, sda_out, power_down, ack;
  logic [2:0] serial_addr_select;
  par_in_t par_in;
  par_out_t par_out;
  logic [511:0] reg_image;
  logic [8:0] rd;
  logic [7:0] sdat;
  int num_errors = 0;
  int check_count = 0;
  video_decoder_control_port dut (.sys_clk(sys_clk), .srst(srst),
    .interface_select_n(interface_select_n), .par_in(par_in), .par_out(par_out),
    .serial_addr_select(serial_addr_select), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .sda_out(sda_out), .power_down(power_down), .reg_image(reg_image));
  host_model host (.sys_clk(sys_clk), .par_out(par_out), .sda_oe(sda_oe),
    .par_in(par_in), .scl_in(scl_in), .sda_in(sda_in));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  function automatic logic [8:0] rb(input int n);
    return {1'b0, reg_image[8*n +: 8]};
  endfunction : rb
  task automatic do_reset();
    int n;
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (20) @(negedge sys_clk);
    check(power_down, 1'b1);
    srst = 1'b0;
    for (n = 0; n < 4 && power_down !== 1'b0; n++) @(negedge sys_clk);
    if (n == 4) begin
      num_errors++;
      end_of_test();
    end
    repeat (6) @(negedge sys_clk);
  endtask : do_reset
  task automatic t_par();
    interface_select_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    host.pacc(1'b0, 1'b0, 8'h3E, rd);
    host.pacc(1'b1, 1'b0, 8'hA5, rd);
    host.pacc(1'b1, 1'b0, 8'h5A, rd);
    host.pacc(1'b1, 1'b0, 8'hC3, rd);
    check(rb(62), 9'h0A5);
    check(rb(63), 9'h0C3);
    host.pacc(1'b0, 1'b1, 8'h00, rd);
    check(rd, 9'h13F);
    host.pacc(1'b1, 1'b1, 8'h00, rd);
    check(rd, 9'h1C3);
    check(par_out.host_data_oe, 1'b0);
  endtask : t_par
  task automatic t_sel();
    interface_select_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    host.pacc(1'b0, 1'b0, 8'h3F, rd);
    host.pacc(1'b1, 1'b0, 8'h77, rd);
    check(rb(63), 9'h0C3);
  endtask : t_sel
  task automatic t_ser();
    serial_addr_select = 3'h5;
    host.start();
    host.sbyte({DEV_ADDR_HIGH, 3'h5, 1'b0}, ack);
    check(ack, 1'b1);
    host.sbyte(8'h20, ack);
    check(ack, 1'b1);
    host.sbyte(8'h11, ack);
    host.sbyte(8'h22, ack);
    check(ack, 1'b1);
    host.stop();
    check(rb(32), 9'h011);
    check(rb(33), 9'h022);
    host.start();
    host.sbyte({DEV_ADDR_HIGH, 3'h5, 1'b0}, ack);
    host.sbyte(8'h20, ack);
    host.stop();
    host.start();
    host.sbyte({DEV_ADDR_HIGH, 3'h5, 1'b1}, ack);
    check(ack, 1'b1);
    host.rbyte(1'b0, sdat);
    check(sdat, 9'h011);
    host.rbyte(1'b1, sdat);
    check(sdat, 9'h022);
    host.stop();
    check(sda_out, 1'b0);
    host.start();
    host.sbyte({DEV_ADDR_HIGH, 3'h2, 1'b0}, ack);
    check(ack, 1'b0);
    host.stop();
  endtask : t_ser
  task automatic t_rst();
    do_reset();
    check(rb(32), 9'h011);
    check(rb(63), 9'h0C3);
    interface_select_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    host.pacc(1'b0, 1'b1, 8'h00, rd);
    check(rd, 9'h100);
  endtask : t_rst
  initial begin
    srst = 1'b1;
    interface_select_n = 1'b1;
    serial_addr_select = 3'h5;
    do_reset();
    t_par();
    t_sel();
    t_ser();
    t_rst();
    end_of_test();
  end
endmodule : video_decoder_control_port_bench
`default_nettype wire
